/* File: hw/hb_master.sv */
// Network end: issues parameter accesses, resets and peer heartbeats.
`default_nettype none
module hb_master
  import hb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  fieldbus_if.master       bus,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_we,
  input  wire logic [15:0] cmd_index,
  input  wire logic [7:0]  cmd_sub,
  input  wire logic [31:0] cmd_wdata,
  output logic             rsp_valid,
  output logic             rsp_abort,
  output logic [31:0]      rsp_data,
  input  wire logic        peer_send,
  input  wire logic [7:0]  peer_node,
  input  wire logic        reset_comm_req,
  input  wire logic        reset_node_req,
  output logic             seen_hb,
  output logic [7:0]       seen_node
);

  typedef enum logic [1:0] {
    M_IDLE = 2'b01,
    M_WAIT = 2'b10
  } master_state_e;

  master_state_e state_ff;
  logic          req_ff;
  logic          we_ff;
  logic [15:0]   index_ff;
  logic [7:0]    sub_ff;
  logic [31:0]   wdata_ff;
  logic          rsp_ff;
  logic          abort_ff;
  logic [31:0]   data_ff;
  logic          peer_ff;
  logic [7:0]    peer_node_ff;
  logic          rst_comm_ff;
  logic          rst_node_ff;
  logic          seen_ff;
  logic [7:0]    seen_node_ff;

  // One access in flight at a time keeps the node's answer unambiguous.
  assign cmd_ready = (state_ff == M_IDLE);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_ff <= M_IDLE;
      req_ff   <= 1'b0;
      we_ff    <= 1'b0;
      index_ff <= 16'h0000;
      sub_ff   <= 8'h00;
      wdata_ff <= 32'h0000_0000;
    end else begin
      req_ff <= 1'b0;
      unique case (state_ff)
        M_IDLE: begin
          if (cmd_valid) begin
            state_ff <= M_WAIT;
            req_ff   <= 1'b1;
            we_ff    <= cmd_we;
            index_ff <= cmd_index;
            sub_ff   <= cmd_sub;
            wdata_ff <= cmd_wdata;
          end
        end
        M_WAIT: begin
          if (bus.sdo_done) begin
            state_ff <= M_IDLE;
          end
        end
        default: begin
          state_ff <= M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rsp_ff   <= 1'b0;
      abort_ff <= 1'b0;
      data_ff  <= 32'h0000_0000;
    end else begin
      rsp_ff <= (state_ff == M_WAIT) && bus.sdo_done;
      if ((state_ff == M_WAIT) && bus.sdo_done) begin
        abort_ff <= bus.sdo_abort;
        data_ff  <= bus.sdo_rdata;
      end
    end
  end

  // Heartbeats are plain pushed frames in both directions.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      peer_ff      <= 1'b0;
      peer_node_ff <= 8'h00;
      rst_comm_ff  <= 1'b0;
      rst_node_ff  <= 1'b0;
      seen_ff      <= 1'b0;
      seen_node_ff <= 8'h00;
    end else begin
      peer_ff     <= peer_send;
      rst_comm_ff <= reset_comm_req;
      rst_node_ff <= reset_node_req;
      seen_ff     <= bus.hb_dev_valid;
      if (peer_send) begin
        peer_node_ff <= peer_node;
      end
      if (bus.hb_dev_valid) begin
        seen_node_ff <= bus.hb_dev_node;
      end
    end
  end

  assign bus.sdo_req        = req_ff;
  assign bus.sdo_we         = we_ff;
  assign bus.sdo_index      = index_ff;
  assign bus.sdo_sub        = sub_ff;
  assign bus.sdo_wdata      = wdata_ff;
  assign bus.hb_net_valid   = peer_ff;
  assign bus.hb_net_node    = peer_node_ff;
  assign bus.nmt_reset_comm = rst_comm_ff;
  assign bus.nmt_reset_node = rst_node_ff;
  assign rsp_valid          = rsp_ff;
  assign rsp_abort          = abort_ff;
  assign rsp_data           = data_ff;
  assign seen_hb            = seen_ff;
  assign seen_node          = seen_node_ff;

endmodule : hb_master
`default_nettype wire

/* File: hw/hb_node.sv */
// Heartbeat producer, heartbeat consumer and store/restore command decode.
`default_nettype none
module hb_node
  import hb_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  fieldbus_if.node        bus,
  input  wire logic [7:0] node_id,
  output logic            hb_fail_pulse,
  output logic [7:0]      hb_fail_node,
  output logic            supervising,
  output logic            store_pulse,
  output logic [1:0]      store_scope,
  output logic            restore_pulse,
  output logic [1:0]      restore_scope
);

  localparam int MS_W = $clog2(MS_CYCLES_P);

  typedef enum logic [2:0] {
    CONS_OFF   = 3'b001,
    CONS_ARMED = 3'b010,
    CONS_WATCH = 3'b100
  } cons_state_e;

  function automatic logic cmd_sub_ok(input logic [7:0] sub);
    return (sub >= SUB_ALL) && (sub <= SUB_APP);
  endfunction

  logic [MS_W-1:0] ms_cnt_ff;
  logic [23:0]     cons_entry_ff;
  logic [15:0]     prod_time_ff, prod_ms_ff, cons_ms_ff, cons_time;
  logic [7:0]      hb_node_ff, fail_node_ff, cons_node;
  logic [31:0]     rdata_ff, nxt_rdata;
  logic [1:0]      scope_ff;
  cons_state_e     cons_state_ff, nxt_cons_state;
  logic            ms_tick, param_rst, hb_out_ff, done_ff, abort_ff;
  logic            nxt_abort, wr_cons, wr_prod, wr_store, wr_restore;
  logic            fail_ff, store_ff, restore_ff, hb_match, expire;

  // Network-commanded resets return every written parameter to default.
  assign param_rst = !resetn || bus.nmt_reset_comm
                     || bus.nmt_reset_node;

  // The millisecond base is never restarted by network resets, so
  // timing of other nodes on a shared divider is unaffected.
  assign ms_tick = (ms_cnt_ff == MS_W'(MS_CYCLES_P - 1));

  always_ff @(posedge clock) begin
    if (!resetn || ms_tick) begin
      ms_cnt_ff <= '0;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 1'b1;
    end
  end

  always_comb begin
    nxt_abort  = 1'b0;
    nxt_rdata  = 32'h0000_0000;
    wr_cons    = 1'b0;
    wr_prod    = 1'b0;
    wr_store   = 1'b0;
    wr_restore = 1'b0;
    unique case (bus.sdo_index)
      IDX_CONSUMER: begin
        if (bus.sdo_sub == SUB_COUNT) begin
          nxt_rdata = CONS_ENTRIES;
          nxt_abort = bus.sdo_we;
        end else if (bus.sdo_sub == SUB_ALL) begin
          nxt_rdata = {8'h00, cons_entry_ff};
          wr_cons   = bus.sdo_we;
        end else begin
          nxt_abort = 1'b1;
        end
      end
      IDX_PRODUCER: begin
        if (bus.sdo_sub == SUB_COUNT) begin
          nxt_rdata = {16'h0000, prod_time_ff};
          wr_prod   = bus.sdo_we;
        end else begin
          nxt_abort = 1'b1;
        end
      end
      IDX_STORE, IDX_RESTORE: begin
        if (bus.sdo_sub == SUB_COUNT) begin
          nxt_rdata = CMD_ENTRIES;
          nxt_abort = bus.sdo_we;
        end else if (cmd_sub_ok(bus.sdo_sub)) begin
          nxt_rdata = CMD_READ_VALUE;
          if (bus.sdo_we && bus.sdo_index == IDX_STORE) begin
            wr_store  = (bus.sdo_wdata == SAVE_WORD);
            nxt_abort = (bus.sdo_wdata != SAVE_WORD);
          end else if (bus.sdo_we) begin
            wr_restore = (bus.sdo_wdata == LOAD_WORD);
            nxt_abort  = (bus.sdo_wdata != LOAD_WORD);
          end
        end else begin
          nxt_abort = 1'b1;
        end
      end
      default: begin
        nxt_abort = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      done_ff  <= 1'b0;
      abort_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      done_ff  <= bus.sdo_req;
      abort_ff <= bus.sdo_req && nxt_abort;
      if (bus.sdo_req && !bus.sdo_we) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (param_rst) begin
      cons_entry_ff <= CONSUMER_RESET;
      prod_time_ff  <= PRODUCER_RESET;
    end else if (bus.sdo_req && wr_cons) begin
      cons_entry_ff <= bus.sdo_wdata[CONS_STORE_W-1:0];
    end else if (bus.sdo_req && wr_prod) begin
      prod_time_ff <= bus.sdo_wdata[15:0];
    end
  end

  // Producer: pushes one frame when the count of ticks hits the period.
  always_ff @(posedge clock) begin
    if (param_rst || (bus.sdo_req && wr_prod)
        || prod_time_ff == 16'h0000) begin
      prod_ms_ff <= 16'h0000;
      hb_out_ff  <= 1'b0;
    end else if (ms_tick && (prod_ms_ff + 16'h0001 == prod_time_ff)) begin
      prod_ms_ff <= 16'h0000;
      hb_out_ff  <= 1'b1;
    end else begin
      prod_ms_ff <= ms_tick ? prod_ms_ff + 16'h0001 : prod_ms_ff;
      hb_out_ff  <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      hb_node_ff <= 8'h00;
    end else begin
      hb_node_ff <= node_id;
    end
  end

  assign cons_time = cons_entry_ff[CONS_TIME_LSB +: CONS_TIME_W];
  assign cons_node = cons_entry_ff[CONS_NODE_LSB +: CONS_NODE_W];
  assign hb_match  = bus.hb_net_valid && (bus.hb_net_node == cons_node);
  // A heartbeat in the expiry cycle wins, so no false failure is seen.
  assign expire    = (cons_state_ff == CONS_WATCH) && ms_tick && !hb_match
                     && (cons_ms_ff + 16'h0001 == cons_time);

  always_comb begin
    nxt_cons_state = cons_state_ff;
    unique case (cons_state_ff)
      CONS_OFF: begin
        if (cons_time != 16'h0000) begin
          nxt_cons_state = CONS_ARMED;
        end
      end
      CONS_ARMED: begin
        if (cons_time == 16'h0000) begin
          nxt_cons_state = CONS_OFF;
        end else if (hb_match) begin
          nxt_cons_state = CONS_WATCH;
        end
      end
      CONS_WATCH: begin
        if (cons_time == 16'h0000) begin
          nxt_cons_state = CONS_OFF;
        end else if (expire) begin
          nxt_cons_state = CONS_ARMED;
        end
      end
      default: begin
        nxt_cons_state = CONS_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (param_rst || (bus.sdo_req && wr_cons)) begin
      cons_state_ff <= CONS_OFF;
    end else begin
      cons_state_ff <= nxt_cons_state;
    end
  end

  always_ff @(posedge clock) begin
    if (param_rst || cons_state_ff != CONS_WATCH || hb_match) begin
      cons_ms_ff <= 16'h0000;
    end else if (ms_tick) begin
      cons_ms_ff <= cons_ms_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      fail_ff      <= 1'b0;
      fail_node_ff <= 8'h00;
    end else begin
      fail_ff <= expire && !(bus.sdo_req && wr_cons);
      if (expire) begin
        fail_node_ff <= cons_node;
      end
    end
  end

  // Commands are only announced here; the persistent memory is outside.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      store_ff   <= 1'b0;
      restore_ff <= 1'b0;
      scope_ff   <= 2'b00;
    end else begin
      store_ff   <= bus.sdo_req && wr_store;
      restore_ff <= bus.sdo_req && wr_restore;
      if (bus.sdo_req && (wr_store || wr_restore)) begin
        scope_ff <= bus.sdo_sub[1:0];
      end
    end
  end

  assign bus.hb_dev_valid = hb_out_ff;
  assign bus.hb_dev_node  = hb_node_ff;
  assign bus.sdo_done     = done_ff;
  assign bus.sdo_abort    = abort_ff;
  assign bus.sdo_rdata    = rdata_ff;
  assign hb_fail_pulse    = fail_ff;
  assign hb_fail_node     = fail_node_ff;
  assign supervising      = (cons_state_ff == CONS_WATCH);
  assign store_pulse      = store_ff;
  assign store_scope      = scope_ff;
  assign restore_pulse    = restore_ff;
  assign restore_scope    = scope_ff;

endmodule : hb_node
`default_nettype wire

/* File: shared/fieldbus_if.sv */
// Frame-level link between the node and the network master or peers.
`default_nettype none
interface fieldbus_if;
  logic        hb_dev_valid;
  logic [7:0]  hb_dev_node;
  logic        hb_net_valid;
  logic [7:0]  hb_net_node;
  logic        sdo_req;
  logic        sdo_we;
  logic [15:0] sdo_index;
  logic [7:0]  sdo_sub;
  logic [31:0] sdo_wdata;
  logic        sdo_done;
  logic        sdo_abort;
  logic [31:0] sdo_rdata;
  logic        nmt_reset_comm;
  logic        nmt_reset_node;

  modport node (
    output hb_dev_valid, hb_dev_node, sdo_done, sdo_abort, sdo_rdata,
    input  hb_net_valid, hb_net_node, sdo_req, sdo_we, sdo_index,
    input  sdo_sub, sdo_wdata, nmt_reset_comm, nmt_reset_node
  );
  modport master (
    input  hb_dev_valid, hb_dev_node, sdo_done, sdo_abort, sdo_rdata,
    output hb_net_valid, hb_net_node, sdo_req, sdo_we, sdo_index,
    output sdo_sub, sdo_wdata, nmt_reset_comm, nmt_reset_node
  );
endinterface : fieldbus_if
`default_nettype wire

/* File: shared/hb_pkg.sv */
// Constants shared by the heartbeat node and its network partner.
`default_nettype none
package hb_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_PERIOD_NS  = 1_000_000;
  localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [15:0] IDX_CONSUMER = 16'h1016;
  localparam logic [15:0] IDX_PRODUCER = 16'h1017;
  localparam logic [15:0] IDX_STORE    = 16'h1010;
  localparam logic [15:0] IDX_RESTORE  = 16'h1011;

  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_ALL   = 8'h01;
  localparam logic [7:0] SUB_COMM  = 8'h02;
  localparam logic [7:0] SUB_APP   = 8'h03;

  localparam int CONS_TIME_LSB = 0;
  localparam int CONS_TIME_W   = 16;
  localparam int CONS_NODE_LSB = 16;
  localparam int CONS_NODE_W   = 8;
  localparam int CONS_STORE_W  = 24;

  localparam logic [23:0] CONSUMER_RESET  = 24'h00_0000;
  localparam logic [15:0] PRODUCER_RESET  = 16'h0000;
  localparam logic [31:0] CONS_ENTRIES    = 32'h0000_0001;
  localparam logic [31:0] CMD_ENTRIES     = 32'h0000_0003;
  localparam logic [31:0] CMD_READ_VALUE  = 32'h0000_0001;

  localparam logic [31:0] SAVE_WORD = 32'h6576_6173;
  localparam logic [31:0] LOAD_WORD = 32'h6461_6F6C;
endpackage : hb_pkg
`default_nettype wire

/* File: test/hb_checker.sv */
// Link checker for the node side of the fieldbus interface.
`default_nettype none
module hb_checker
  import hb_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        sdo_req,
  input wire logic        sdo_we,
  input wire logic [15:0] sdo_index,
  input wire logic [7:0]  sdo_sub,
  input wire logic [31:0] sdo_wdata,
  input wire logic        sdo_done,
  input wire logic        sdo_abort,
  input wire logic [31:0] sdo_rdata,
  input wire logic        hb_dev_valid,
  input wire logic        nmt_reset_comm,
  input wire logic        nmt_reset_node
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic        wr;
  logic        sub_ok;
  logic        rd_cons;
  logic [15:0] prod_ff;
  assign wr = sdo_req && sdo_we;
  assign sub_ok = sdo_sub inside {SUB_ALL, SUB_COMM, SUB_APP};
  assign rd_cons = sdo_req && !sdo_we && sdo_index == IDX_CONSUMER;
  // Shadow of the cycle time, one cycle late so in-flight pulses pass.
  always_ff @(posedge clock) begin
    if (!resetn || nmt_reset_comm || nmt_reset_node) begin
      prod_ff <= 16'h0000;
    end else if (sdo_done && !sdo_abort && sdo_we &&
                 sdo_index == IDX_PRODUCER) begin
      prod_ff <= sdo_wdata[15:0];
    end
  end
  done_after_req_a: assert property (sdo_req |=> sdo_done)
    else $error("request not answered next cycle");
  abort_with_done_a: assert property (sdo_abort |-> sdo_done)
    else $error("abort without done");
  save_ok_a: assert property (wr && sdo_index == IDX_STORE && sub_ok &&
    sdo_wdata == SAVE_WORD |=> !sdo_abort) else $error("save refused");
  save_bad_a: assert property (wr && sdo_index == IDX_STORE &&
    sdo_wdata != SAVE_WORD |=> sdo_abort) else $error("bad save taken");
  load_ok_a: assert property (wr && sdo_index == IDX_RESTORE && sub_ok &&
    sdo_wdata == LOAD_WORD |=> !sdo_abort) else $error("load refused");
  cmd_sub_a: assert property (wr && (sdo_index == IDX_STORE ||
    sdo_index == IDX_RESTORE) && !sub_ok |=> sdo_abort)
    else $error("bad command sub taken");
  entry_count_a: assert property (rd_cons && sdo_sub == SUB_COUNT
    |=> sdo_rdata == CONS_ENTRIES) else $error("entry count wrong");
  reserved_zero_a: assert property (rd_cons && sdo_sub == SUB_ALL
    |=> sdo_rdata[31:24] == 8'h00) else $error("reserved bits set");
  zero_silent_a: assert property (prod_ff == 16'h0000 &&
    $past(prod_ff) == 16'h0000 |-> !hb_dev_valid)
    else $error("heartbeat with zero cycle time");
  beat_single_a: assert property (hb_dev_valid |=> !hb_dev_valid)
    else $error("heartbeat longer than one cycle");
  save_cov: cover property (wr && sdo_index == IDX_STORE ##1 !sdo_abort);
  abort_cov: cover property (sdo_abort);
  beat_cov: cover property (hb_dev_valid);
endmodule // hb_checker
`default_nettype wire

/* File: test/tb_top.sv */
// Bench joining node and network ends with scripted and random traffic.
`default_nettype none
module tb_top
  import hb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 20;
  logic clock = 1'h0, resetn = 1'h0, cmd_valid = 1'h0, cmd_we = 1'h0;
  logic [15:0] cmd_index = 16'h0;
  logic [7:0]  cmd_sub = 8'h0, peer_node = 8'h0, node_id = 8'h2A, seen_node;
  logic [31:0] cmd_wdata = 32'h0, rsp_data;
  logic peer_send = 1'h0, reset_comm_req = 1'h0, reset_node_req = 1'h0;
  logic cmd_ready, rsp_valid, rsp_abort, seen_hb, hb_fail_pulse;
  logic supervising, store_pulse, restore_pulse;
  logic [7:0]  hb_fail_node;
  logic [1:0]  store_scope, restore_scope, st_sc, rs_sc;
  int err_total = 0, cmp_count = 0, cyc = 0, hb_cnt = 0, hb_last = 0;
  int hb_gap = 0, st_cnt = 0, rs_cnt = 0, fail_cnt = 0, fail_cyc = 0;
  int sh_cnt = 0;
  fieldbus_if bus();
  hb_node #(.MS_CYCLES_P(MS)) u_hb_node (.clock, .resetn, .bus(bus),
    .node_id, .hb_fail_pulse, .hb_fail_node, .supervising, .store_pulse,
    .store_scope, .restore_pulse, .restore_scope);
  hb_master u_hb_master (.clock, .resetn, .bus(bus), .cmd_valid,
    .cmd_ready, .cmd_we, .cmd_index, .cmd_sub, .cmd_wdata, .rsp_valid,
    .rsp_abort, .rsp_data, .peer_send, .peer_node, .reset_comm_req,
    .reset_node_req, .seen_hb, .seen_node);
  hb_checker u_hb_checker (.clock, .resetn, .sdo_req(bus.sdo_req),
    .sdo_we(bus.sdo_we), .sdo_index(bus.sdo_index),
    .sdo_sub(bus.sdo_sub), .sdo_wdata(bus.sdo_wdata),
    .sdo_done(bus.sdo_done), .sdo_abort(bus.sdo_abort),
    .sdo_rdata(bus.sdo_rdata), .hb_dev_valid(bus.hb_dev_valid),
    .nmt_reset_comm(bus.nmt_reset_comm),
    .nmt_reset_node(bus.nmt_reset_node));
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (bus.hb_dev_valid === 1'h1) begin
      hb_gap <= cyc - hb_last;
      hb_last <= cyc;
      hb_cnt <= hb_cnt + 1;
    end
    if (store_pulse === 1'h1) begin
      st_cnt <= st_cnt + 1;
      st_sc <= store_scope;
    end
    if (restore_pulse === 1'h1) begin
      rs_cnt <= rs_cnt + 1;
      rs_sc <= restore_scope;
    end
    if (hb_fail_pulse === 1'h1) begin
      fail_cnt <= fail_cnt + 1;
      fail_cyc <= cyc;
    end
    if (seen_hb === 1'h1) begin
      sh_cnt <= sh_cnt + 1;
    end
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Consumer entry as read back: reserved byte always reads zero.
  function automatic logic [31:0] entry_rd(logic [7:0] nd, logic [15:0] tm);
    return {8'h00, nd, tm};
  endfunction
  function automatic int gap_exp(int ms_count);
    return ms_count * MS;
  endfunction
  // One parameter access; read data is compared only when it is valid.
  task automatic xfer(logic we, logic [15:0] ix, logic [7:0] sb,
                      logic [31:0] wd, logic [31:0] ed, logic ea);
    int n;
    @(negedge clock);
    cmd_valid = 1'h1;
    cmd_we = we;
    cmd_index = ix;
    cmd_sub = sb;
    cmd_wdata = wd;
    @(negedge clock);
    cmd_valid = 1'h0;
    check("cmd_ready", 32'(cmd_ready), 32'h0);
    n = 0;
    while (rsp_valid !== 1'h1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    check("rsp_valid", 32'(rsp_valid), 32'h1);
    check("rsp_abort", 32'(rsp_abort), 32'(ea));
    if (!we && !ea) check("rsp_data", rsp_data, ed);
  endtask
  task automatic beat(logic [7:0] nd);
    @(negedge clock);
    peer_send = 1'h1;
    peer_node = nd;
    @(negedge clock);
    peer_send = 1'h0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    summarize();
  end
  initial begin
    logic [31:0] w;
    logic [7:0]  nd;
    int t, k, c0, n;
    w = $urandom(72761);
    repeat (16) @(negedge clock);
    resetn = 1'h1;
    xfer(1'h0, IDX_CONSUMER, SUB_COUNT, 32'h0, CONS_ENTRIES, 1'h0);
    xfer(1'h0, IDX_CONSUMER, SUB_ALL, 32'h0, 32'h0, 1'h0);
    xfer(1'h0, IDX_PRODUCER, SUB_COUNT, 32'h0, 32'h0, 1'h0);
    xfer(1'h1, IDX_CONSUMER, SUB_COUNT, 32'h1, 32'h0, 1'h1);
    xfer(1'h0, 16'h2000, SUB_COUNT, 32'h0, 32'h0, 1'h1);
    $display("test reset_values done");
    for (int s = 1; s <= 3; s++) begin
      xfer(1'h1, IDX_STORE, s[7:0], SAVE_WORD, 32'h0, 1'h0);
      check("store_scope", 32'(st_sc), s);
      xfer(1'h1, IDX_RESTORE, s[7:0], LOAD_WORD, 32'h0, 1'h0);
      check("restore_scope", 32'(rs_sc), s);
      do w = $urandom(); while (w == SAVE_WORD);
      xfer(1'h1, IDX_STORE, s[7:0], w, 32'h0, 1'h1);
      xfer(1'h1, IDX_RESTORE, s[7:0], SAVE_WORD, 32'h0, 1'h1);
      xfer(1'h0, IDX_RESTORE, s[7:0], 32'h0, CMD_READ_VALUE, 1'h0);
    end
    xfer(1'h1, IDX_STORE, SUB_COUNT, SAVE_WORD, 32'h0, 1'h1);
    xfer(1'h1, IDX_RESTORE, 8'h04, LOAD_WORD, 32'h0, 1'h1);
    xfer(1'h1, IDX_STORE, SUB_ALL, 32'h7361_7665, 32'h0, 1'h1);
    check("store_count", st_cnt, 3);
    check("restore_count", rs_cnt, 3);
    $display("test commands done");
    t = 1 + $urandom() % 3;
    xfer(1'h1, IDX_PRODUCER, SUB_COUNT, 32'(t), 32'h0, 1'h0);
    k = hb_cnt;
    // Parameter traffic runs meanwhile; the beat must not care.
    repeat (t * MS)
      xfer(1'h0, IDX_PRODUCER, SUB_COUNT, 32'h0, 32'(t), 1'h0);
    check("beat_gap", hb_gap, gap_exp(t));
    check("beat_seen", 32'(hb_cnt > k + 1), 32'h1);
    check("seen_node", 32'(seen_node), 32'(node_id));
    xfer(1'h1, IDX_PRODUCER, SUB_COUNT, 32'h0, 32'h0, 1'h0);
    k = hb_cnt;
    repeat (5 * MS) @(negedge clock);
    check("beat_count", hb_cnt, k);
    check("seen_count", sh_cnt, hb_cnt);
    $display("test producer done");
    nd = 8'h40 + 8'($urandom() % 32);
    t = 3 + $urandom() % 3;
    xfer(1'h1, IDX_CONSUMER, SUB_ALL, {8'hA5, nd, 16'h0}, 32'h0, 1'h0);
    beat(nd);
    repeat (3) @(negedge clock);
    check("supervising", 32'(supervising), 32'h0);
    xfer(1'h1, IDX_CONSUMER, SUB_ALL, {8'hA5, nd, 16'(t)}, 32'h0,
         1'h0);
    xfer(1'h0, IDX_CONSUMER, SUB_ALL, 32'h0, entry_rd(nd, 16'(t)),
         1'h0);
    k = fail_cnt;
    repeat (3 * t * MS) @(negedge clock);
    beat(nd ^ 8'h01);
    repeat (3) @(negedge clock);
    check("supervising", 32'(supervising), 32'h0);
    beat(nd);
    repeat (3) @(negedge clock);
    check("supervising", 32'(supervising), 32'h1);
    repeat (4) begin
      repeat (MS) @(negedge clock);
      beat(nd);
    end
    check("fail_count", fail_cnt, k);
    c0 = cyc;
    n = 0;
    while (fail_cnt == k && n < (t + 2) * MS) begin
      @(negedge clock);
      n++;
    end
    n = fail_cyc - c0;
    check("fail_time", 32'(n >= (t-1)*MS - 2 && n <= t*MS + 4), 32'h1);
    check("fail_node", 32'(hb_fail_node), 32'(nd));
    check("supervising", 32'(supervising), 32'h0);
    $display("test consumer done");
    for (int r = 0; r < 2; r++) begin
      xfer(1'h1, IDX_PRODUCER, SUB_COUNT, 32'h00FF, 32'h0, 1'h0);
      xfer(1'h1, IDX_CONSUMER, SUB_ALL, {8'h0, nd, 16'h9}, 32'h0,
           1'h0);
      if (r == 1) begin
        xfer(1'h1, IDX_RESTORE, SUB_ALL, LOAD_WORD, 32'h0, 1'h0);
      end
      @(negedge clock);
      reset_comm_req = (r == 0);
      reset_node_req = (r == 1);
      @(negedge clock);
      reset_comm_req = 1'h0;
      reset_node_req = 1'h0;
      repeat (3) @(negedge clock);
      xfer(1'h0, IDX_PRODUCER, SUB_COUNT, 32'h0, 32'h0, 1'h0);
      xfer(1'h0, IDX_CONSUMER, SUB_ALL, 32'h0, 32'h0, 1'h0);
      if (r == 1) begin
        xfer(1'h1, IDX_STORE, SUB_ALL, SAVE_WORD, 32'h0, 1'h0);
      end
    end
    check("store_count", st_cnt, 4);
    check("restore_count", rs_cnt, 4);
    $display("test network_reset done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
